// *** hdl/hfs_supervisor.sv ***
// Purpose: fault supervision and restart control for a hot-swap power path
// Assumes: comparator levels arrive asynchronously; register port is a simple strobed command port
// Notes: analog loops, insertion delay and address capture sit outside
`default_nettype none
module hfs_supervisor
    import hfs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        limit_select_strap,
    input  wire logic        breaker_select_strap,
    input  wire logic        retry_strap,
    input  wire logic        over_limit_25,
    input  wire logic        over_limit_46,
    input  wire logic [3:0]  over_breaker,
    input  wire logic        power_threshold_input,
    input  wire logic        undervolt_enable_input,
    input  wire logic        overvolt_input,
    input  wire logic        insertion_done,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    output logic             reg_rvalid,
    output logic             gate_on,
    output logic             gate_regulate,
    output logic             gate_strong_pulldown,
    output logic             alert_output,
    output logic             cl_high_select,
    output logic             cb_high_select
);
    logic [1:0]  strap_cl_s;
    logic [1:0]  strap_cb_s;
    logic [1:0]  strap_rt_s;
    logic [1:0]  lim25_s;
    logic [1:0]  lim46_s;
    logic [7:0]  cb_s;
    logic [1:0]  pwr_s;
    logic [1:0]  uv_s;
    logic [1:0]  ov_s;
    logic [1:0]  ins_s;
    logic        en_ok;
    logic        ov_hi;
    logic        ins_ok;
    logic        en_ok_d;
    logic        powered_up;
    logic [7:0]  setup;
    logic [15:0] mask;
    logic [7:0]  operation;
    logic        op_enable;
    logic        flag_oc;
    logic        flag_uv;
    logic        flag_ov;
    logic        flag_cb;
    logic        limiting;
    logic        breaker;
    logic        cur_lim;
    logic        sel_cl_high;
    logic        sel_cb_high;
    logic [2:0]  retry_code;
    logic        retry_inf;
    logic [4:0]  retry_limit;
    logic [4:0]  retry_used;
    hfs_state_e  state;
    hfs_state_e  next_state;
    logic [2:0]  cycle_cnt;
    logic        falling;
    logic [15:0] tmr_level;
    logic        tmr_charge;
    logic        tmr_fast;
    logic        timeout_evt;
    logic        run_ok;
    logic        latch_release;
    logic        cb_evt;
    logic [15:0] summary_word;
    logic [7:0]  input_stat;
    logic [7:0]  vendor_stat;
    logic [15:0] diag_word;
    logic        clr;

    // two-stage synchronisers for pins and comparators
    always_ff @(posedge mclk) begin
        if (rst) begin
            strap_cl_s <= 2'h0;
            strap_cb_s <= 2'h0;
            strap_rt_s <= 2'h0;
            lim25_s    <= 2'h0;
            lim46_s    <= 2'h0;
            cb_s       <= 8'h00;
            pwr_s      <= 2'h0;
            uv_s       <= 2'h0;
            ov_s       <= 2'h0;
            ins_s      <= 2'h0;
        end else begin
            strap_cl_s <= {strap_cl_s[0], limit_select_strap};
            strap_cb_s <= {strap_cb_s[0], breaker_select_strap};
            strap_rt_s <= {strap_rt_s[0], retry_strap};
            lim25_s    <= {lim25_s[0], over_limit_25};
            lim46_s    <= {lim46_s[0], over_limit_46};
            cb_s       <= {cb_s[3:0], over_breaker};
            pwr_s      <= {pwr_s[0], power_threshold_input};
            uv_s       <= {uv_s[0], undervolt_enable_input};
            ov_s       <= {ov_s[0], overvolt_input};
            ins_s      <= {ins_s[0], insertion_done};
        end
    end

    assign en_ok  = uv_s[1];
    assign ov_hi  = ov_s[1];
    assign ins_ok = ins_s[1];

    // threshold and multiplier selection, setup overrides the straps
    assign sel_cl_high = setup[SU_CL_OVR_BIT] ? setup[SU_CL_SEL_BIT] : strap_cl_s[1];
    assign sel_cb_high = setup[SU_CB_OVR_BIT] ? setup[SU_CB_SEL_BIT] : strap_cb_s[1];
    always_ff @(posedge mclk) begin
        if (rst) begin
            cl_high_select <= 1'b0;
            cb_high_select <= 1'b0;
        end else begin
            cl_high_select <= sel_cl_high;
            cb_high_select <= sel_cb_high;
        end
    end
    assign cur_lim  = sel_cl_high ? lim46_s[1] : lim25_s[1];
    // breaker comparators: [0] 1.8x of 25, [1] 3.6x of 25, [2] 1.8x of 46, [3] 3.6x of 46
    assign breaker  = cb_s[7 - 3 + {sel_cl_high, sel_cb_high}];
    assign limiting = cur_lim | pwr_s[1];

    // retry allowance, pin gives none or unlimited
    assign retry_code = setup[SU_RETRY_OVR_BIT] ? setup[SU_RETRY_LSB +: 3]
                        : (strap_rt_s[1] ? RETRY_0 : RETRY_INF);
    assign retry_inf  = (retry_code == RETRY_INF) || (retry_code == 3'h7);
    always_comb begin
        unique case (retry_code)
            RETRY_0:  retry_limit = 5'h00;
            RETRY_1:  retry_limit = 5'h01;
            RETRY_2:  retry_limit = 5'h02;
            RETRY_4:  retry_limit = 5'h04;
            RETRY_8:  retry_limit = 5'h08;
            RETRY_16: retry_limit = 5'h10;
            default:  retry_limit = 5'h00;
        endcase
    end

    assign op_enable   = operation[7];
    assign run_ok      = en_ok & ~ov_hi & ins_ok & op_enable;
    assign timeout_evt = (state == HFS_TIMEOUT) && (tmr_level >= TMR_HIGH);
    assign latch_release = en_ok & ~en_ok_d;

    // operating state machine
    always_comb begin
        next_state = state;
        unique case (state)
            HFS_OFF:     if (run_ok) next_state = HFS_ON;
            HFS_ON: begin
                if (!run_ok) next_state = HFS_OFF;
                else if (limiting || breaker) next_state = HFS_TIMEOUT;
            end
            HFS_TIMEOUT: begin
                if (!run_ok) next_state = HFS_OFF;
                else if (timeout_evt) begin
                    if (retry_inf || (retry_used < retry_limit)) next_state = HFS_RETRY;
                    else next_state = HFS_LATCHED;
                end else if (!limiting && !breaker) next_state = HFS_ON;
            end
            HFS_RETRY: begin
                if (!run_ok) next_state = HFS_OFF;
                else if (falling && cycle_cnt == RESTART_CYCLES && tmr_level <= TMR_LOW) begin
                    next_state = HFS_ON;
                end
            end
            HFS_LATCHED: begin
                if (latch_release && tmr_level < TMR_LOW) next_state = HFS_OFF;
            end
            default: next_state = HFS_OFF;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= HFS_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            en_ok_d <= 1'b0;
        end else begin
            en_ok_d <= en_ok;
        end
    end

    // restart ramp cycling between high and mid levels
    always_ff @(posedge mclk) begin
        if (rst) begin
            falling   <= 1'b1;
            cycle_cnt <= 3'h0;
        end else if (state != HFS_RETRY) begin
            falling   <= 1'b1;
            cycle_cnt <= 3'h0;
        end else if (falling && cycle_cnt != RESTART_CYCLES && tmr_level <= TMR_MID) begin
            falling <= 1'b0;
        end else if (!falling && tmr_level >= TMR_HIGH) begin
            falling   <= 1'b1;
            cycle_cnt <= cycle_cnt + 3'h1;
        end
    end

    // retries consumed since last good run
    always_ff @(posedge mclk) begin
        if (rst) begin
            retry_used <= 5'h00;
        end else if (state == HFS_OFF || (state == HFS_TIMEOUT && next_state == HFS_ON)) begin
            retry_used <= 5'h00;
        end else if (state == HFS_TIMEOUT && next_state == HFS_RETRY && retry_used != 5'h1f) begin
            retry_used <= retry_used + 5'h01;
        end
    end

    assign tmr_charge = (state == HFS_TIMEOUT) || (state == HFS_RETRY && !falling);
    assign tmr_fast   = (state == HFS_ON) || (state == HFS_OFF);

    hfs_timer u_timer (
        .mclk           (mclk),
        .rst            (rst),
        .charge         (tmr_charge),
        .fast_discharge (tmr_fast),
        .level          (tmr_level)
    );

    // gate drive
    always_ff @(posedge mclk) begin
        if (rst) begin
            gate_on              <= 1'b0;
            gate_regulate        <= 1'b0;
            gate_strong_pulldown <= 1'b1;
        end else begin
            gate_on              <= (next_state == HFS_ON) || (next_state == HFS_TIMEOUT && !breaker);
            gate_regulate        <= (next_state == HFS_TIMEOUT) && limiting && !breaker;
            gate_strong_pulldown <= (next_state == HFS_TIMEOUT) && breaker;
        end
    end

    // register writes
    assign clr = reg_wr && reg_addr == ADDR_CLEAR_FAULTS && reg_wdata[7:0] == CMD_CLEAR_FAULTS;
    always_ff @(posedge mclk) begin
        if (rst) begin
            setup     <= SETUP_RESET;
            mask      <= MASK_RESET;
            operation <= OPERATION_ON;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_SETUP) setup <= reg_wdata[7:0];
            if (reg_addr == ADDR_ALERT_MASK) mask <= reg_wdata;
            if (reg_addr == ADDR_OPERATION && reg_wdata[7:0] != CMD_CLEAR_FAULTS) begin
                operation <= reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            powered_up <= 1'b0;
        end else if (en_ok && ins_ok) begin
            powered_up <= 1'b1;
        end
    end

    assign cb_evt = breaker && state == HFS_TIMEOUT;

    // sticky fault flags, set wins over clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_oc <= 1'b0;
            flag_uv <= 1'b0;
            flag_ov <= 1'b0;
            flag_cb <= 1'b0;
        end else begin
            flag_oc <= (timeout_evt && limiting) | (flag_oc & ~clr);
            flag_uv <= (powered_up && !en_ok) | (flag_uv & ~clr);
            flag_ov <= ov_hi | (flag_ov & ~clr);
            flag_cb <= cb_evt | (flag_cb & ~clr);
        end
    end

    assign input_stat   = {flag_ov, 2'b00, flag_uv, 2'b00, flag_oc, 1'b0};
    assign summary_word = {2'b00, flag_oc | flag_uv | flag_ov, 13'h0000};
    assign vendor_stat  = {5'h00, flag_cb, 2'b00};
    assign diag_word    = {1'b0, flag_oc, flag_uv, flag_ov, 2'b00, flag_cb, 4'h0,
                           state == HFS_LATCHED, 4'h0};

    // alert is any set flag whose mask bit is clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            alert_output <= 1'b0;
        end else begin
            alert_output <= (flag_oc & ~mask[DG_OCOP_BIT]) | (flag_uv & ~mask[DG_UV_BIT])
                          | (flag_ov & ~mask[DG_OV_BIT]) | (flag_cb & ~mask[DG_CB_BIT]);
        end
    end

    // register reads, one cycle latency
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    ADDR_STATUS_WORD:   reg_rdata <= summary_word;
                    ADDR_INPUT_STATUS:  reg_rdata <= {8'h00, input_stat};
                    ADDR_VENDOR_STATUS: reg_rdata <= {8'h00, vendor_stat};
                    ADDR_ALERT_MASK:    reg_rdata <= mask;
                    ADDR_SETUP:         reg_rdata <= {8'h00, setup};
                    ADDR_DIAG:          reg_rdata <= diag_word;
                    ADDR_OPERATION:     reg_rdata <= {8'h00, operation};
                    default:            reg_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule // hfs_supervisor
`default_nettype wire

// *** hdl/hfs_pkg.sv ***
// Purpose: constants for the hot-swap fault supervisor
// Assumes: 200 MHz mclk, digital comparator levels from the analog front end
// Notes: register map follows the documented command codes
`default_nettype none
package hfs_pkg;
    localparam logic [7:0] ADDR_STATUS_WORD = 8'h79;
    localparam logic [7:0] ADDR_INPUT_STATUS = 8'h7c;
    localparam logic [7:0] ADDR_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] ADDR_ALERT_MASK = 8'hd8;
    localparam logic [7:0] ADDR_SETUP = 8'hd9;
    localparam logic [7:0] ADDR_DIAG = 8'he1;
    localparam logic [7:0] ADDR_OPERATION = 8'h03;
    localparam logic [7:0] ADDR_CLEAR_FAULTS = 8'h03 + 8'h00;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h01;
    localparam logic [7:0] OPERATION_ON = 8'h80;
    localparam logic [7:0] OPERATION_OFF = 8'h00;
    // input_status bits
    localparam int IN_OV_BIT = 7;
    localparam int IN_UV_BIT = 4;
    localparam int IN_OC_BIT = 1;
    // summary word input bit
    localparam int SW_INPUT_BIT = 13;
    // vendor status breaker bit
    localparam int VS_CB_BIT = 2;
    // fault_diagnostics bits
    localparam int DG_OCOP_BIT = 14;
    localparam int DG_UV_BIT = 13;
    localparam int DG_OV_BIT = 12;
    localparam int DG_CB_BIT = 9;
    localparam int DG_LATCH_BIT = 4;
    // protection_setup fields
    localparam int SU_RETRY_LSB = 5;
    localparam int SU_CL_OVR_BIT = 4;
    localparam int SU_CL_SEL_BIT = 3;
    localparam int SU_CB_OVR_BIT = 2;
    localparam int SU_CB_SEL_BIT = 1;
    localparam int SU_RETRY_OVR_BIT = 0;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    // retry codes in protection_setup
    localparam logic [2:0] RETRY_0 = 3'h0;
    localparam logic [2:0] RETRY_1 = 3'h1;
    localparam logic [2:0] RETRY_2 = 3'h2;
    localparam logic [2:0] RETRY_4 = 3'h3;
    localparam logic [2:0] RETRY_8 = 3'h4;
    localparam logic [2:0] RETRY_16 = 3'h5;
    localparam logic [2:0] RETRY_INF = 3'h6;
    // timer comparator thresholds in counts
    localparam logic [15:0] TMR_HIGH = 16'h0aa0;
    localparam logic [15:0] TMR_MID = 16'h0640;
    localparam logic [15:0] TMR_LOW = 16'h012c;
    localparam logic [2:0] RESTART_CYCLES = 3'h7;
    // ramp slopes per clock: charge, slow discharge and fast discharge
    localparam logic [15:0] TMR_CHARGE_STEP = 16'h0020;
    localparam logic [15:0] TMR_SLOW_STEP = 16'h0001;
    localparam logic [15:0] TMR_FAST_STEP = 16'h0100;
    typedef enum logic [2:0] {
        HFS_OFF     = 3'b000,
        HFS_ON      = 3'b001,
        HFS_TIMEOUT = 3'b010,
        HFS_RETRY   = 3'b011,
        HFS_LATCHED = 3'b100
    } hfs_state_e;
endpackage : hfs_pkg
`default_nettype wire

// *** hdl/hfs_timer.sv ***
// Purpose: digital model of the fault timer capacitor ramp
// Assumes: one clock, synchronous reset
// Notes: value saturates at zero and at full scale
`default_nettype none
module hfs_timer
    import hfs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        charge,
    input  wire logic        fast_discharge,
    output logic [15:0]      level
);
    always_ff @(posedge mclk) begin
        if (rst) begin
            level <= 16'h0000;
        end else if (charge) begin
            level <= (level > 16'hffff - TMR_CHARGE_STEP) ? 16'hffff : level + TMR_CHARGE_STEP;
        end else if (fast_discharge) begin
            level <= (level < TMR_FAST_STEP) ? 16'h0000 : level - TMR_FAST_STEP;
        end else begin
            level <= (level < TMR_SLOW_STEP) ? 16'h0000 : level - TMR_SLOW_STEP;
        end
    end
endmodule // hfs_timer
`default_nettype wire

// *** tb/hfs_supervisor_sva.sv ***
// Purpose: port-level checks of the hot-swap fault supervisor
// Assumes: setup and mask shadows rebuilt from register writes
// Notes: inputs take two sync edges plus one output edge
`default_nettype none
module hfs_supervisor_sva
    import hfs_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        limit_select_strap,
    input wire logic [3:0]  over_breaker,
    input wire logic        power_threshold_input,
    input wire logic        undervolt_enable_input,
    input wire logic        overvolt_input,
    input wire logic        insertion_done,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        gate_on,
    input wire logic        gate_regulate,
    input wire logic        gate_strong_pulldown,
    input wire logic        alert_output,
    input wire logic        cl_high_select,
    input wire logic        cb_high_select
);
    logic [7:0]  setup_sh;
    logic [15:0] mask_sh;
    always_ff @(posedge mclk) begin
        if (rst) begin
            setup_sh <= SETUP_RESET;
        end else if (reg_wr && reg_addr == ADDR_SETUP) begin
            setup_sh <= reg_wdata[7:0];
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            mask_sh <= MASK_RESET;
        end else if (reg_wr && reg_addr == ADDR_ALERT_MASK) begin
            mask_sh <= reg_wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_ov_gate_off: assert property (overvolt_input [*5] |-> !gate_on)
        else $error("gate on during overvoltage");
    chk_uv_gate_off: assert property (!undervolt_enable_input [*5] |-> !gate_on)
        else $error("gate on while enable low");
    chk_insert_gate_off: assert property (!insertion_done [*5] |-> !gate_on)
        else $error("gate on before insertion delay");
    chk_pulldown_excl: assert property (gate_strong_pulldown |-> !gate_on)
        else $error("gate on with strong pull-down");
    chk_breaker_pulldown: assert property ($rose(&over_breaker) |-> ##[1:5] gate_strong_pulldown)
        else $error("no strong pull-down after breaker trip");
    chk_alert_fall_cause: assert property ($fell(alert_output) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("alert dropped without a register write");
    chk_cl_override: assert property (reg_wr && reg_addr == ADDR_SETUP && reg_wdata[SU_CL_OVR_BIT]
        |=> ##1 cl_high_select == $past(reg_wdata[SU_CL_SEL_BIT], 2))
        else $error("limit override not applied");
    chk_cb_override: assert property (reg_wr && reg_addr == ADDR_SETUP && reg_wdata[SU_CB_OVR_BIT]
        |=> ##1 cb_high_select == $past(reg_wdata[SU_CB_SEL_BIT], 2))
        else $error("breaker override not applied");
    chk_cl_strap_follow: assert property ((!setup_sh[SU_CL_OVR_BIT] && $stable(limit_select_strap)) [*4]
        |-> cl_high_select == limit_select_strap)
        else $error("limit select does not follow strap");
    chk_ov_alert: assert property ((overvolt_input && !mask_sh[DG_OV_BIT] && !reg_wr) [*6] |-> alert_output)
        else $error("no alert on unmasked overvoltage");
    chk_power_regulate: assert property ((power_threshold_input && gate_on) [*5] |-> gate_regulate)
        else $error("no regulation at power limit");
endmodule // hfs_supervisor_sva
bind hfs_supervisor hfs_supervisor_sva hfs_supervisor_sva_i (.mclk, .rst, .limit_select_strap, .over_breaker,
    .power_threshold_input, .undervolt_enable_input, .overvolt_input, .insertion_done, .reg_wr, .reg_addr,
    .reg_wdata, .gate_on, .gate_regulate, .gate_strong_pulldown, .alert_output, .cl_high_select, .cb_high_select);
`default_nettype wire

// *** tb/hfs_power_path.sv ***
// Purpose: pass transistor and sense comparators seen by the supervisor
// Assumes: load_mode 0 normal, 1 overload, 2 power limit, 3 short
// Notes: current flows only while the gate is on and not pulled down
`default_nettype none
module hfs_power_path
    import hfs_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       gate_on,
    input  wire logic       gate_strong_pulldown,
    input  wire logic [1:0] load_mode,
    output logic            over_limit_25,
    output logic            over_limit_46,
    output logic [3:0]      over_breaker,
    output logic            power_threshold_input
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [6:0] sense = 7'h00;
    logic       flow;
    assign flow = gate_on && !gate_strong_pulldown;
    always @(posedge mclk) begin
        #1;
        sense[1:0] = {2{flow && load_mode[0]}};
        sense[5:2] = {4{flow && load_mode == 2'd3}};
        sense[6] = flow && load_mode == 2'd2;
    end
    assign over_limit_25 = sense[0];
    assign over_limit_46 = sense[1];
    assign over_breaker = sense[5:2];
    assign power_threshold_input = sense[6];
endmodule // hfs_power_path
`default_nettype wire

// *** tb/test_hotswap_fault_supervisor.sv ***
// Purpose: self-checking bench for the hot-swap fault supervisor
// Assumes: partner drives the comparators from the gate outputs
// Notes: flag expectations kept in a small model
`default_nettype none
module test_hotswap_fault_supervisor
    import hfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 0, rst = 1, limit_select_strap = 0, breaker_select_strap = 0, retry_strap = 1;
    logic        over_limit_25, over_limit_46, power_threshold_input, reg_rvalid, saw_pd = 0;
    logic        undervolt_enable_input = 1, overvolt_input = 0, insertion_done = 0, reg_wr = 0, reg_rd = 0;
    logic        gate_on, gate_regulate, gate_strong_pulldown, alert_output, cl_high_select, cb_high_select;
    logic [3:0]  over_breaker;
    logic [1:0]  load_mode = 0;
    logic [7:0]  reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, exp_in = 0, exp_dg = 0, mask_m = 0;
    logic [31:0] lfsr = 32'h36cb45b2;
    int          mismatches = 0, checked = 0;
    logic [2:0]  codes[$] = '{RETRY_0, RETRY_1, RETRY_2, RETRY_4, RETRY_8, RETRY_16, RETRY_INF};
    hfs_supervisor hfs_supervisor_i (.mclk, .rst, .limit_select_strap, .breaker_select_strap, .retry_strap,
        .over_limit_25, .over_limit_46, .over_breaker, .power_threshold_input, .undervolt_enable_input,
        .overvolt_input, .insertion_done, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .gate_on, .gate_regulate, .gate_strong_pulldown, .alert_output, .cl_high_select, .cb_high_select);
    hfs_power_path hfs_power_path_i (.mclk, .gate_on, .gate_strong_pulldown, .load_mode, .over_limit_25,
        .over_limit_46, .over_breaker, .power_threshold_input);
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (!rst && gate_strong_pulldown === 1'b1) saw_pd <= 1'b1;
    end
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
        reg_wr = 0;
        tick(1);
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
        reg_rd = 1;
        reg_addr = a;
        tick(1);
        reg_rd = 0;
        compare({15'h0, reg_rvalid}, 16'h1);
        compare(reg_rdata & m, exp & m);
        tick(1);
    endtask
    task automatic check_flags;
        reg_read(ADDR_INPUT_STATUS, exp_in, 16'h0092);
        reg_read(ADDR_STATUS_WORD, {2'b0, exp_in != 16'h0, 13'h0}, 16'h2000);
        reg_read(ADDR_VENDOR_STATUS, {13'h0, exp_dg[DG_CB_BIT], 2'b0}, 16'h0004);
        reg_read(ADDR_DIAG, exp_dg, 16'h7210);
        compare({15'h0, alert_output}, {15'h0, |(exp_dg & ~mask_m & 16'h7200)});
    endtask
    task automatic wait_gate(input logic v, input int bound);
        for (int i = 0; i < bound && gate_on !== v; i++) tick(1);
        compare({15'h0, gate_on}, {15'h0, v});
        if (gate_on !== v) print_verdict;
    endtask
    task automatic pulse_enable;
        undervolt_enable_input = 0;
        tick(8);
        undervolt_enable_input = 1;
        tick(1);
    endtask
    task automatic clear_all;
        reg_write(ADDR_CLEAR_FAULTS, {8'h0, CMD_CLEAR_FAULTS});
        exp_in = 0;
        exp_dg = 0;
        check_flags;
    endtask
    initial begin
        tick(16);
        rst = 0;
        tick(1);
        reg_read(ADDR_SETUP, {8'h0, SETUP_RESET}, 16'h00ff);
        reg_read(ADDR_ALERT_MASK, MASK_RESET, 16'hffff);
        reg_read(8'h55, 16'h0, 16'hffff);
        reg_write(ADDR_DIAG, 16'hffff);
        lfsr = next_rand(lfsr);
        reg_write(ADDR_ALERT_MASK, lfsr[15:0]);
        reg_read(ADDR_ALERT_MASK, lfsr[15:0], 16'hffff);
        reg_write(ADDR_ALERT_MASK, 16'h0);
        foreach (codes[i]) begin
            reg_write(ADDR_SETUP, {8'h0, codes[i], 5'h01});
            reg_read(ADDR_SETUP, {8'h0, codes[i], 5'h01}, 16'h00ff);
        end
        limit_select_strap = 1;
        breaker_select_strap = 1;
        reg_write(ADDR_SETUP, 16'h0);
        tick(4);
        compare({14'h0, cl_high_select, cb_high_select}, 16'h3);
        reg_write(ADDR_SETUP, 16'h0014);
        compare({14'h0, cl_high_select, cb_high_select}, 16'h0);
        reg_write(ADDR_SETUP, 16'h0);
        insertion_done = 1;
        wait_gate(1, 20);
        check_flags;
        repeat (2) begin
            lfsr = next_rand(lfsr);
            load_mode = 1;
            tick(40 + lfsr[3:0]);
            compare({15'h0, gate_regulate}, 16'h1);
            load_mode = 0;
            tick(100);
        end
        compare({15'h0, gate_on}, 16'h1);
        check_flags;
        load_mode = 2;
        wait_gate(0, 300);
        load_mode = 0;
        pulse_enable;
        exp_in = 16'h0012;
        exp_dg = 16'h6010;
        tick(20);
        compare({15'h0, gate_on}, 16'h0);
        check_flags;
        tick(3000);
        pulse_enable;
        wait_gate(1, 50);
        exp_dg[DG_LATCH_BIT] = 0;
        check_flags;
        clear_all;
        reg_write(ADDR_OPERATION, {8'h0, OPERATION_OFF});
        tick(4);
        compare({15'h0, gate_on}, 16'h0);
        reg_write(ADDR_OPERATION, {8'h0, OPERATION_ON});
        wait_gate(1, 20);
        mask_m = 16'h2000;
        reg_write(ADDR_ALERT_MASK, mask_m);
        pulse_enable;
        exp_in = 16'h0010;
        exp_dg = 16'h2000;
        check_flags;
        mask_m = 0;
        reg_write(ADDR_ALERT_MASK, mask_m);
        check_flags;
        wait_gate(1, 20);
        clear_all;
        overvolt_input = 1;
        tick(6);
        compare({15'h0, gate_on}, 16'h0);
        exp_in = 16'h0080;
        exp_dg = 16'h1000;
        check_flags;
        overvolt_input = 0;
        wait_gate(1, 20);
        clear_all;
        saw_pd = 0;
        load_mode = 3;
        tick(10);
        load_mode = 0;
        compare({15'h0, saw_pd}, 16'h1);
        tick(10);
        compare({14'h0, gate_on, gate_strong_pulldown}, 16'h2);
        exp_dg = 16'h0200;
        check_flags;
        clear_all;
        reg_write(ADDR_SETUP, {8'h0, RETRY_1, 5'h01});
        load_mode = 1;
        wait_gate(0, 300);
        wait_gate(1, 15000);
        wait_gate(0, 300);
        tick(15000);
        compare({15'h0, gate_on}, 16'h0);
        exp_in = 16'h0002;
        exp_dg = 16'h4010;
        check_flags;
        reg_write(ADDR_SETUP, 16'h0);
        retry_strap = 0;
        pulse_enable;
        wait_gate(1, 50);
        repeat (2) begin
            wait_gate(0, 300);
            wait_gate(1, 15000);
        end
        print_verdict;
    end
endmodule // test_hotswap_fault_supervisor
`default_nettype wire
